// ### tb_top.sv
// Self-checking bench for the memory access guard
`timescale 1ns/100ps
`include "tmg_consts.vh"
module tb_top;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, verify_valid = 0, access_write = 0;
  logic contactless_ownership_flag = 0, go = 0, pwr = 1;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, verify_value = 0, rd;
  logic [3:0] s_axi_wstrb = 0;
  logic [7:0] access_page = 8'hff, nclk = 8'h02;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire verify_done, verify_ok, access_denied, host_owns_memory;
  wire vcc_powered, link_clk, link_active, busy;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] verify_ack;
  int err_count = 0, samples_checked = 0, cyc = 0, n;
  localparam logic [31:0] PW = 32'h44332211;
  tmg_guard dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .vcc_powered(vcc_powered), .link_clk(link_clk), .link_active(link_active),
    .contactless_ownership_flag(contactless_ownership_flag),
    .verify_valid(verify_valid), .verify_value(verify_value), .verify_done(verify_done),
    .verify_ok(verify_ok), .verify_ack(verify_ack),
    .access_page(access_page), .access_write(access_write), .access_denied(access_denied),
    .host_owns_memory(host_owns_memory)
  );
  tmg_host_model u_host (
    .go(go), .nclk(nclk), .pwr(pwr), .vcc_powered(vcc_powered), .link_clk(link_clk),
    .link_active(link_active), .busy(busy)
  );
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 12000) begin
      err_count++;
      print_verdict;
    end
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task chk(input [31:0] g, input [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [4:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task rdr(input [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task vfy(input [31:0] v, input eok, input [15:0] eack);
    @(posedge aclk);
    verify_valid <= 1'b1;
    verify_value <= v;
    @(posedge aclk);
    verify_valid <= 1'b0;
    @(posedge aclk);
    chk(32'(verify_done), 32'h1);
    chk(32'(verify_ok), 32'(eok));
    chk(32'(verify_ack), 32'(eack));
  endtask
  task wown(input v, input int lim);
    n = 0;
    while (host_owns_memory !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task frame(input [7:0] k);
    @(posedge aclk);
    nclk <= k;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    wown(1'b1, 100);
  endtask
  task acc(input [7:0] p, input e);
    @(posedge aclk);
    access_page <= p;
    access_write <= 1'b1;
    @(posedge aclk);
    @(posedge aclk);
    chk(32'(access_denied), 32'(e));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_defaults;
    rdr(`TMG_OFF_PERIOD); chk(rd, 32'h848);
    rdr(`TMG_OFF_CONFIG); chk(rd, 32'hff);
    rdr(`TMG_OFF_STATUS); chk(rd, 32'h8);
    rdr(5'h18); chk(32'(rs), 32'(`TMG_RESP_SLVERR));
  endtask
  task t_secrets;
    wr(`TMG_OFF_PASS, 32'h11, 4'h1, `TMG_RESP_OKAY);
    wr(`TMG_OFF_PASS, 32'h44332200, 4'he, `TMG_RESP_OKAY);
    rdr(`TMG_OFF_PASS); chk(rd, 32'h0);
    wr(`TMG_OFF_ACK, 32'hbeef, 4'h3, `TMG_RESP_OKAY);
    rdr(`TMG_OFF_ACK); chk(rd, 32'h0);
    vfy(PW, 1'b1, 16'hbeef);
    vfy(32'h11223344, 1'b0, 16'h0);
    rdr(`TMG_OFF_FAILS); chk(rd, 32'h0);
  endtask
  task t_protect;
    wr(`TMG_OFF_CONFIG, 32'h110, 4'hf, `TMG_RESP_OKAY);
    acc(8'h20, 1'b1);
    acc(8'h05, 1'b0);
    wr(`TMG_OFF_PASS, PW, 4'hf, `TMG_RESP_SLVERR);
    vfy(32'h0, 1'b0, 16'h0);
    rdr(`TMG_OFF_FAILS); chk(rd, 32'h1);
    vfy(PW, 1'b1, 16'hbeef);
    rdr(`TMG_OFF_FAILS); chk(rd, 32'h0);
    wr(`TMG_OFF_PASS, PW, 4'hf, `TMG_RESP_OKAY);
    vfy(32'h1, 1'b0, 16'h0);
    vfy(32'h2, 1'b0, 16'h0);
    rdr(`TMG_OFF_STATUS); chk(32'(rd[2]), 32'h1);
    vfy(PW, 1'b0, 16'h0);
    acc(8'h20, 1'b1);
  endtask
  task t_watchdog;
    wr(`TMG_OFF_PERIOD, 32'h1, 4'h3, `TMG_RESP_OKAY);
    frame(8'h02); chk(32'(host_owns_memory), 32'h1);
    wown(1'b0, 700); chk(32'(n >= 465 && n <= 480), 32'h1);
    // Frame outlasts the 471-cycle period
    frame(8'h40);
    n = 0;
    while (busy && n < 800) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(host_owns_memory), 32'h1);
    wown(1'b0, 10); chk(32'(n < 8), 32'h1);
  endtask
  task t_owner;
    wr(`TMG_OFF_PERIOD, 32'h2, 4'h3, `TMG_RESP_OKAY);
    frame(8'h02);
    repeat (600) @(posedge aclk);
    rdr(`TMG_OFF_STATUS); chk(32'(rd[0]), 32'h1);
    chk(32'(rd[5]), 32'h1);
    wr(`TMG_OFF_STATUS, 32'h0, 4'h1, `TMG_RESP_OKAY);
    chk(32'(host_owns_memory), 32'h0);
    contactless_ownership_flag <= 1'b1;
    wr(`TMG_OFF_STATUS, 32'h1, 4'h1, `TMG_RESP_OKAY);
    chk(32'(host_owns_memory), 32'h0);
    rdr(`TMG_OFF_STATUS); chk(32'(rd[1]), 32'h1);
    chk(32'(rd[5]), 32'h0);
    contactless_ownership_flag <= 1'b0;
  endtask
  // Supply loss halts the watchdog, so the claim outlives the period
  task t_power;
    wr(`TMG_OFF_PERIOD, 32'h1, 4'h3, `TMG_RESP_OKAY);
    frame(8'h02);
    pwr <= 1'b0;
    repeat (600) @(posedge aclk);
    chk(32'(host_owns_memory), 32'h1);
    rdr(`TMG_OFF_STATUS); chk(rd, 32'h5);
    pwr <= 1'b1;
    wr(`TMG_OFF_STATUS, 32'h0, 4'h1, `TMG_RESP_OKAY);
    chk(32'(host_owns_memory), 32'h0);
  endtask
  task print_verdict;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_defaults;
    t_secrets;
    t_protect;
    t_watchdog;
    t_owner;
    t_power;
    print_verdict;
  end
endmodule
bind tmg_guard tmg_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .verify_valid(verify_valid),
  .verify_done(verify_done), .verify_ok(verify_ok), .verify_ack(verify_ack),
  .contactless_ownership_flag(contactless_ownership_flag),
  .host_owns_memory(host_owns_memory)
);

// ### tmg_chk.sv
// Concurrent checks on the guard's register, verify and ownership ports
`timescale 1ns/100ps
`include "tmg_consts.vh"
module tmg_chk (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire verify_valid,
  input wire verify_done,
  input wire verify_ok,
  input wire [15:0] verify_ack,
  input wire contactless_ownership_flag,
  input wire host_owns_memory
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_secret_taken;
    s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr == `TMG_OFF_PASS || s_axi_araddr == `TMG_OFF_ACK);
  endsequence
  sequence s_zero_answer;
    s_axi_rvalid && s_axi_rdata == 32'h0;
  endsequence
  property p_verify_done; verify_valid |=> verify_done; endproperty
  a_verify_done: assert property (p_verify_done) else $error("verify unanswered");
  property p_verify_quiet; !verify_valid |=> !verify_done; endproperty
  a_verify_quiet: assert property (p_verify_quiet) else $error("stray done");
  property p_ack_idle; !verify_ok |-> verify_ack == 16'h0; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without match");
  property p_ok_done; verify_ok |-> verify_done; endproperty
  a_ok_done: assert property (p_ok_done) else $error("ok without done");
  property p_secret_zero; s_secret_taken |=> s_zero_answer; endproperty
  a_secret_zero: assert property (p_secret_zero) else $error("secret readable");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rf_keeps; contactless_ownership_flag && !host_owns_memory |=> !host_owns_memory;
  endproperty
  a_rf_keeps: assert property (p_rf_keeps) else $error("claim while contactless owns");
endmodule

// ### tmg_consts.vh
// Constants for the tag memory access guard
// Function
// - Host ownership held until host or watchdog clears it
// - Watchdog expiry silently clears ownership flag
// - Sixteen-bit period, default 848h, 9.43 us
// - Watchdog starts when serial communication begins
// - Expiry mid-transaction waits for transaction end
// - Expiry after transaction clears flag at once
// - Halt watchdog unpowered or contactless-owned idle
// - 32-bit password and 16-bit acknowledge stored
// - Page FFh disables protection, fields writable
// - Protection starts at first protected page
// - Password and acknowledge stored low byte first
// - Password and acknowledge read back as zero
// - Protected fields writable only after verification
// - Limit 000b disables failure counting entirely
// - Count failures, lock at two power limit
// - After lock every verification fails
// - Successful verification clears failure counter
// - Configuration pages protected, level bit selects
// - Status bit shows attempt limit reached
// - Ownership flag reads one, host writable
`ifndef TMG_CONSTS_VH
`define TMG_CONSTS_VH
// -----------------------------------------------
// Register byte offsets
// -----------------------------------------------
`define TMG_OFF_STATUS 5'h00
`define TMG_OFF_PERIOD 5'h04
`define TMG_OFF_CONFIG 5'h08
`define TMG_OFF_PASS 5'h0c
`define TMG_OFF_ACK 5'h10
`define TMG_OFF_FAILS 5'h14
// -----------------------------------------------
// Field positions and reset values
// -----------------------------------------------
`define TMG_ST_OWN 0
`define TMG_ST_RF 1
`define TMG_ST_LIMIT 2
`define TMG_ST_VCC 3
`define TMG_ST_AUTH 4
`define TMG_ST_BUSY 5
`define TMG_CFG_LIM_LSB 8
`define TMG_CFG_LEVEL 11
`define TMG_RST_PERIOD 16'h0848
`define TMG_RST_PAGE 8'hff
`define TMG_RST_LIMIT 3'h0
`define TMG_PAGE_OFF 8'hff
`define TMG_RESP_OKAY 2'h0
`define TMG_RESP_SLVERR 2'h2
// -----------------------------------------------
// Timing
// -----------------------------------------------
`define TMG_CLK_MHZ 50
`define TMG_TICK_NS 9430
`define TMG_TICK_CYC ((`TMG_TICK_NS * `TMG_CLK_MHZ) / 1000)
`endif

// ### tmg_guard.v
// Memory access guard: ownership watchdog and password protection
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "tmg_consts.vh"
module tmg_guard (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite register port
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pins from the serial-bus side
  input wire vcc_powered,
  input wire link_clk,
  input wire link_active,
  // Contactless side, same clock
  input wire contactless_ownership_flag,
  input wire verify_valid,
  input wire [31:0] verify_value,
  output reg verify_done,
  output reg verify_ok,
  output reg [15:0] verify_ack,
  // Memory access check, same clock
  input wire [7:0] access_page,
  input wire access_write,
  output wire access_denied,
  output wire host_owns_memory
);
  // -----------------------------------------------
  // State
  // -----------------------------------------------
  reg owner;
  reg exp_pending;
  reg [15:0] wd_period;
  reg [7:0] first_protected_page;
  reg [2:0] failed_attempt_limit;
  reg protection_level_select;
  reg [31:0] access_password;
  reg [15:0] password_acknowledge;
  reg [7:0] fail_count;
  reg authenticated;
  reg link_clk_d;
  reg in_session;
  wire [2:0] pins;
  wire vcc_s;
  wire link_clk_s;
  wire active_s;
  wire wd_running;
  wire wd_expire;
  wire wd_halt;
  wire sess_start;
  wire prot_on;
  wire limit_reached;
  wire fields_writable;

  tmg_sync #(
    .W(3)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({vcc_powered, link_clk, link_active}),
    .q(pins)
  );

  assign vcc_s = pins[2];
  assign link_clk_s = pins[1];
  assign active_s = pins[0];

  // -----------------------------------------------
  // Helpers
  // -----------------------------------------------
  function lim_hit;
    input [2:0] lim;
    input [7:0] cnt;
    begin
      lim_hit = (lim != 3'h0) && ({1'b0, cnt} >= (9'h001 << lim));
    end
  endfunction

  // Merge one byte lane set into a word
  function [31:0] lanes;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      lanes = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lanes[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  assign prot_on = (first_protected_page != `TMG_PAGE_OFF);
  assign limit_reached = lim_hit(failed_attempt_limit, fail_count);
  assign fields_writable = !prot_on || authenticated;
  assign host_owns_memory = owner;

  // -----------------------------------------------
  // Session detection from the link clock
  // -----------------------------------------------
  // A session begins at the first link clock edge while active
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_clk_d <= 1'b0;
      in_session <= 1'b0;
    end else begin
      link_clk_d <= link_clk_s;
      in_session <= active_s && (in_session || sess_start);
    end
  end

  assign sess_start = active_s && !in_session && link_clk_s && !link_clk_d;

  // -----------------------------------------------
  // Watchdog
  // -----------------------------------------------
  // Powered down, or idle with the contactless side owning memory
  assign wd_halt = !vcc_s || (!owner && contactless_ownership_flag);

  tmg_watchdog u_wd (
    .aclk(aclk),
    .aresetn(aresetn),
    .halt(wd_halt),
    .start(sess_start),
    .period(wd_period),
    .running(wd_running),
    .expire(wd_expire)
  );

  // -----------------------------------------------
  // AXI4-Lite write channel
  // -----------------------------------------------
  reg aw_held;
  reg w_held;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_go;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TMG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `TMG_OFF_STATUS, `TMG_OFF_PERIOD, `TMG_OFF_CONFIG,
          `TMG_OFF_FAILS: s_axi_bresp <= `TMG_RESP_OKAY;
          `TMG_OFF_PASS, `TMG_OFF_ACK: begin
            s_axi_bresp <= fields_writable ? `TMG_RESP_OKAY : `TMG_RESP_SLVERR;
          end
          default: s_axi_bresp <= `TMG_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // -----------------------------------------------
  // Configuration registers
  // -----------------------------------------------
  wire wr_cfg;
  wire wr_pass;
  wire wr_ack;
  wire [31:0] period_merged = lanes({16'h0000, wd_period}, w_data, w_strb);
  wire [31:0] ack_merged = lanes({16'h0000, password_acknowledge}, w_data, {2'b00, w_strb[1:0]});

  assign wr_cfg = wr_go && (aw_addr == `TMG_OFF_CONFIG);
  assign wr_pass = wr_go && (aw_addr == `TMG_OFF_PASS) && fields_writable;
  assign wr_ack = wr_go && (aw_addr == `TMG_OFF_ACK) && fields_writable;

  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_period <= `TMG_RST_PERIOD;
      first_protected_page <= `TMG_RST_PAGE;
      failed_attempt_limit <= `TMG_RST_LIMIT;
      protection_level_select <= 1'b0;
      access_password <= 32'h00000000;
      password_acknowledge <= 16'h0000;
    end else begin
      // Zero period is not a legal setting and is ignored
      if (wr_go && aw_addr == `TMG_OFF_PERIOD) begin
        if (period_merged[15:0] != 16'h0000) begin
          wd_period <= period_merged[15:0];
        end
      end
      if (wr_cfg && w_strb[0]) begin
        first_protected_page <= w_data[7:0];
      end
      if (wr_cfg && w_strb[1]) begin
        failed_attempt_limit <= w_data[`TMG_CFG_LIM_LSB +: 3];
        protection_level_select <= w_data[`TMG_CFG_LEVEL];
      end
      // Lane 0 holds the first byte sent on the link
      if (wr_pass) begin
        access_password <= lanes(access_password, w_data, w_strb);
      end
      if (wr_ack) begin
        password_acknowledge <= ack_merged[15:0];
      end
    end
  end

  // -----------------------------------------------
  // Ownership flag
  // -----------------------------------------------
  wire own_claim;
  wire own_drop;
  wire host_clear;

  assign host_clear = wr_go && (aw_addr == `TMG_OFF_STATUS) && w_strb[0] &&
    !w_data[`TMG_ST_OWN];
  assign own_claim = (sess_start && !contactless_ownership_flag) ||
    (wr_go && (aw_addr == `TMG_OFF_STATUS) && w_strb[0] &&
    w_data[`TMG_ST_OWN] && !contactless_ownership_flag);
  // Expiry during a transaction waits for the transaction to close
  assign own_drop = host_clear || (wd_expire && !active_s) ||
    (exp_pending && !active_s);

  always @(posedge aclk) begin
    if (!aresetn) begin
      owner <= 1'b0;
      exp_pending <= 1'b0;
    end else begin
      if (own_claim) begin
        owner <= 1'b1;
      end else if (own_drop) begin
        owner <= 1'b0;
      end
      exp_pending <= !wd_halt && active_s && (exp_pending || wd_expire);
    end
  end

  // -----------------------------------------------
  // Password verification
  // -----------------------------------------------
  wire match;

  assign match = (verify_value == access_password);

  always @(posedge aclk) begin
    if (!aresetn) begin
      verify_done <= 1'b0;
      verify_ok <= 1'b0;
      verify_ack <= 16'h0000;
      fail_count <= 8'h00;
      authenticated <= 1'b0;
    end else begin
      verify_done <= verify_valid;
      verify_ok <= 1'b0;
      verify_ack <= 16'h0000;
      if (verify_valid) begin
        if (limit_reached) begin
          authenticated <= 1'b0;
        end else if (match) begin
          verify_ok <= 1'b1;
          verify_ack <= password_acknowledge;
          fail_count <= 8'h00;
          authenticated <= 1'b1;
        end else begin
          authenticated <= 1'b0;
          if (failed_attempt_limit != 3'h0) begin
            fail_count <= fail_count + 8'h01;
          end
        end
      end
    end
  end

  // -----------------------------------------------
  // Memory access check
  // -----------------------------------------------
  // Level bit set guards reads too; config pages fall in the range
  assign access_denied = prot_on && (access_page >= first_protected_page) &&
    (access_write || protection_level_select) &&
    (!authenticated || limit_reached);

  // -----------------------------------------------
  // AXI4-Lite read channel
  // -----------------------------------------------
  reg [31:0] rd_word;

  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      `TMG_OFF_STATUS: begin
        rd_word[`TMG_ST_OWN] = owner;
        rd_word[`TMG_ST_RF] = contactless_ownership_flag;
        rd_word[`TMG_ST_LIMIT] = limit_reached;
        rd_word[`TMG_ST_VCC] = vcc_s;
        rd_word[`TMG_ST_AUTH] = authenticated;
        rd_word[`TMG_ST_BUSY] = wd_running;
      end
      `TMG_OFF_PERIOD: rd_word[15:0] = wd_period;
      `TMG_OFF_CONFIG: begin
        rd_word[7:0] = first_protected_page;
        rd_word[`TMG_CFG_LIM_LSB +: 3] = failed_attempt_limit;
        rd_word[`TMG_CFG_LEVEL] = protection_level_select;
      end
      // Secrets are never returned
      `TMG_OFF_PASS, `TMG_OFF_ACK: rd_word = 32'h00000000;
      `TMG_OFF_FAILS: rd_word[7:0] = fail_count;
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TMG_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        case (s_axi_araddr)
          `TMG_OFF_STATUS, `TMG_OFF_PERIOD, `TMG_OFF_CONFIG, `TMG_OFF_PASS,
          `TMG_OFF_ACK, `TMG_OFF_FAILS: s_axi_rresp <= `TMG_RESP_OKAY;
          default: s_axi_rresp <= `TMG_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### tmg_host_model.sv
// Serial-bus host model: supply pin, link clock and transaction frame
`timescale 1ns/100ps
module tmg_host_model (
  input wire go,
  input wire [7:0] nclk,
  input wire pwr,
  output logic vcc_powered,
  output logic link_clk,
  output logic link_active,
  output logic busy
);
  // ----------------------------------------
  // Frame generator
  // ----------------------------------------
  assign vcc_powered = pwr;
  initial begin
    link_clk = 1'b0;
    link_active = 1'b0;
    busy = 1'b0;
  end
  // Clock stands low outside frames; odd offset keeps it off aclk phase
  always @(posedge go) begin
    busy = 1'b1;
    #7 link_active = 1'b1;
    #80;
    repeat (nclk) begin
      link_clk = 1'b1;
      #80 link_clk = 1'b0;
      #80;
    end
    link_active = 1'b0;
    busy = 1'b0;
  end
endmodule

// ### tmg_sync.v
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module tmg_sync #(
  parameter W = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ### tmg_watchdog.v
// Watchdog tick divider and period counter
`timescale 1ns/100ps
`include "tmg_consts.vh"
module tmg_watchdog (
  input wire aclk,
  input wire aresetn,
  input wire halt,
  input wire start,
  input wire [15:0] period,
  output reg running,
  output reg expire
);
  localparam [31:0] TICK_FULL = `TMG_TICK_CYC - 1;
  localparam [15:0] TICK_LAST = TICK_FULL[15:0];
  reg [15:0] div;
  reg [15:0] ticks;
  wire tick;

  assign tick = (div == TICK_LAST);

  // Halt resets everything, so a new start always counts a full period
  always @(posedge aclk) begin
    if (!aresetn || halt) begin
      div <= 16'h0000;
      ticks <= 16'h0000;
      running <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start && !running) begin
        running <= 1'b1;
        div <= 16'h0000;
        ticks <= 16'h0000;
      end else if (running) begin
        div <= tick ? 16'h0000 : div + 16'h0001;
        if (tick) begin
          if (ticks + 16'h0001 >= period) begin
            running <= 1'b0;
            expire <= 1'b1;
          end else begin
            ticks <= ticks + 16'h0001;
          end
        end
      end
    end
  end
endmodule
